// File: core/dlc_pkg.sv
// Constants, types and register map of the display list coprocessor.
package dlc_pkg;
    // Timing: one memory cycle is 280 ns, the system clock runs at 10 ns.
    localparam int CLK_PERIOD_NS = 10;
    localparam int MEM_CYCLE_NS = 280;
    localparam int MEM_CYC_CLKS = MEM_CYCLE_NS / CLK_PERIOD_NS;
    localparam logic [4:0] MC_FIRST = 5'h00;
    localparam logic [4:0] MC_LAST = 5'(MEM_CYC_CLKS - 1);

    // Register addresses on the software port and on the chip register bus.
    localparam logic [8:0] ADDR_CTRL = 9'h0a0;
    localparam logic [8:0] ADDR_LOC1H = 9'h0a2;
    localparam logic [8:0] ADDR_LOC1L = 9'h0a4;
    localparam logic [8:0] ADDR_LOC2H = 9'h0a6;
    localparam logic [8:0] ADDR_LOC2L = 9'h0a8;
    localparam logic [8:0] ADDR_JMP1 = 9'h0aa;
    localparam logic [8:0] ADDR_JMP2 = 9'h0ac;
    localparam logic [8:0] ADDR_MARKER = 9'h0ae;
    localparam logic [8:0] ADDR_DMACTL = 9'h0b0;
    localparam logic [8:0] ADDR_STATUS = 9'h0b2;
    localparam logic [8:0] ADDR_IDLE = 9'h1fe;
    // Block-transfer engine register window.
    localparam logic [8:0] BLIT_LO = 9'h040;
    localparam logic [8:0] BLIT_HI = 9'h07e;

    // Field positions.
    localparam int CTRL_DANGER_BIT = 1;
    localparam int DMA_MASTER_BIT = 9;
    localparam int DMA_COPROC_BIT = 7;
    localparam int IR_TYPE_BIT = 0;
    localparam int IR2_FD_BIT = 15;
    localparam int IR2_SKIP_BIT = 0;

    // Reset values and the program counter step.
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [17:0] RST_PTR = 18'h00000;
    localparam logic [17:0] PC_STEP = 18'h00002;

    typedef enum logic [1:0] {
        ST_FETCH1 = 2'b00,
        ST_FETCH2 = 2'b01,
        ST_WAIT = 2'b10,
        ST_WAKE = 2'b11
    } dlc_state_t;

    typedef struct packed {
        logic wr;
        logic [8:0] addr;
        logic [15:0] data;
    } dlc_regbus_t;

    typedef struct packed {
        logic req;
        logic [17:0] addr;
    } dlc_dma_t;
endpackage

// File: core/dlc_top.sv
// Display list coprocessor: instruction fetch, MOVE/WAIT/SKIP and registers.
`timescale 1ns/1ps

// Behaviour
// - Blitter registers written only with danger bit set
// - Reset clears the danger bit
// - Jump strobe write loads pc from pointer
// - Own MOVE to jump strobe also jumps
// - Pointers are 18 bits: 3 high, 15 low
// - Vertical blank reloads pc from first pointer
// - Fetch cycles show marker address on register bus, except a MOVE's second fetch
// - MOVE: destination bits 8:1, data second word
// - WAIT/SKIP position and mask field layout
// - Only enabled position bits are compared
// - WAIT holds off bus until position reached
// - SKIP bypasses next MOVE when position reached
// - Finished-disable set ignores blitter finished flag
// - Otherwise blitter finished flag also required
// - Top vertical bit always compared
// - Bus requested only on odd memory cycles
// - Arbiter ranks coprocessor above blitter and processor
// - MOVE and SKIP take two fetch cycles
// - Fetch only with master and own DMA enable
// - MOVE uses 4 slots, WAIT uses 6
module dlc_top
    import dlc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [8:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    output dlc_dma_t dma,
    input wire logic dma_gnt,
    input wire logic [15:0] dma_rdata,
    output dlc_regbus_t regbus,
    input wire logic [7:0] beam_v,
    input wire logic [6:0] beam_h,
    input wire logic blit_done,
    input wire logic vblank_start
);

    // Tells whether an address names one of this block's own registers.
    function automatic logic is_own(input logic [8:0] a);
        is_own = (a == ADDR_CTRL) || (a == ADDR_LOC1H) || (a == ADDR_LOC1L) ||
                 (a == ADDR_LOC2H) || (a == ADDR_LOC2L) || (a == ADDR_JMP1) ||
                 (a == ADDR_JMP2) || (a == ADDR_DMACTL);
    endfunction

    // Masked beam test; the top vertical bit has no mask and always counts.
    function automatic logic beam_met(input logic [15:0] ir1,
                                      input logic [15:0] ir2,
                                      input logic [7:0] bv,
                                      input logic [6:0] bh,
                                      input logic done);
        logic [14:0] mask;
        logic [14:0] pos;
        logic [14:0] beam;
        mask = {1'b1, ir2[14:8], ir2[7:1]};
        pos = {ir1[15:8], ir1[7:1]} & mask;
        beam = {bv, bh} & mask;
        beam_met = (beam >= pos) && (ir2[IR2_FD_BIT] || done);
    endfunction

    logic [4:0] mc_cnt_q;
    logic odd_q;
    logic [15:0] ctrl_q;
    logic [15:0] dmactl_q;
    logic [2:0] loc1h_q;
    logic [14:0] loc1l_q;
    logic [2:0] loc2h_q;
    logic [14:0] loc2l_q;
    logic [17:0] pc_q;
    logic [15:0] ir1_q;
    logic [15:0] ir2_q;
    logic skip_q;
    logic slot_q;
    dlc_state_t state_q;
    dlc_regbus_t regbus_q;
    dlc_dma_t dma_q;
    logic [15:0] rdata_q;

    logic cyc_start;
    logic cyc_end;
    logic run_en;
    logic [17:0] ptr1;
    logic [17:0] ptr2;
    logic ir1_move;
    logic slot_done;
    logic move_commit;
    logic move_blit;
    logic move_ok;
    logic int_we;
    logic [8:0] int_addr;
    logic [15:0] int_data;
    logic jump1;
    logic jump2;
    logic wait_cond;

    assign cyc_start = (mc_cnt_q == MC_FIRST);
    assign cyc_end = (mc_cnt_q == MC_LAST);
    assign run_en = dmactl_q[DMA_MASTER_BIT] && dmactl_q[DMA_COPROC_BIT];
    assign ptr1 = {loc1h_q, loc1l_q};
    assign ptr2 = {loc2h_q, loc2l_q};
    assign ir1_move = !ir1_q[IR_TYPE_BIT];
    assign slot_done = slot_q && cyc_end && dma_gnt;
    assign move_commit = slot_done && (state_q == ST_FETCH2) && ir1_move;
    assign move_blit = (ir1_q[8:0] >= BLIT_LO) && (ir1_q[8:0] <= BLIT_HI);
    // A skipped MOVE and a blitter MOVE without the danger bit never write.
    assign move_ok = !skip_q && !(move_blit && !ctrl_q[CTRL_DANGER_BIT]);
    assign wait_cond = beam_met(ir1_q, ir2_q, beam_v, beam_h, blit_done);

    // Software writes win over a colliding MOVE into the same registers.
    always_comb begin
        int_we = reg_wr || (move_commit && move_ok);
        int_addr = reg_wr ? reg_addr : {ir1_q[8:1], 1'b0};
        int_data = reg_wr ? reg_wdata : dma_rdata;
    end

    assign jump1 = int_we && (int_addr == ADDR_JMP1);
    assign jump2 = int_we && (int_addr == ADDR_JMP2);

    // Memory cycle divider; the parity flag marks the odd cycles we may use.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            mc_cnt_q <= MC_FIRST;
            odd_q <= 1'b0;
        end else if (cyc_end) begin
            mc_cnt_q <= MC_FIRST;
            odd_q <= !odd_q;
        end else begin
            mc_cnt_q <= mc_cnt_q + 5'h01;
        end
    end

    // Own registers, written by software or by the coprocessor's MOVE.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ctrl_q <= RST_WORD;
            dmactl_q <= RST_WORD;
            loc1h_q <= RST_PTR[17:15];
            loc1l_q <= RST_PTR[14:0];
            loc2h_q <= RST_PTR[17:15];
            loc2l_q <= RST_PTR[14:0];
        end else if (int_we && is_own(int_addr)) begin
            unique case (int_addr)
                ADDR_CTRL: begin
                    ctrl_q <= int_data & (16'h0001 << CTRL_DANGER_BIT);
                end
                ADDR_DMACTL: begin
                    dmactl_q <= int_data;
                end
                ADDR_LOC1H: begin
                    loc1h_q <= int_data[2:0];
                end
                ADDR_LOC1L: begin
                    loc1l_q <= int_data[14:0];
                end
                ADDR_LOC2H: begin
                    loc2h_q <= int_data[2:0];
                end
                ADDR_LOC2L: begin
                    loc2l_q <= int_data[14:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Sequencer: jumps and vertical blank restart, otherwise fetch and test.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_q <= ST_FETCH1;
            pc_q <= RST_PTR;
            ir1_q <= RST_WORD;
            ir2_q <= RST_WORD;
            skip_q <= 1'b0;
        end else if (vblank_start || jump1 || jump2) begin
            state_q <= ST_FETCH1;
            pc_q <= jump2 && !vblank_start ? ptr2 : ptr1;
            skip_q <= 1'b0;
        end else begin
            unique case (state_q)
                ST_FETCH1: begin
                    if (slot_done) begin
                        ir1_q <= dma_rdata;
                        pc_q <= pc_q + PC_STEP;
                        state_q <= ST_FETCH2;
                    end
                end
                ST_FETCH2: begin
                    if (slot_done) begin
                        ir2_q <= dma_rdata;
                        pc_q <= pc_q + PC_STEP;
                        if (ir1_move) begin
                            skip_q <= 1'b0;
                            state_q <= ST_FETCH1;
                        end else if (dma_rdata[IR2_SKIP_BIT]) begin
                            // Decide now whether the next MOVE is bypassed.
                            skip_q <= beam_met(ir1_q, dma_rdata, beam_v, beam_h,
                                               blit_done);
                            state_q <= ST_FETCH1;
                        end else begin
                            skip_q <= 1'b0;
                            state_q <= ST_WAIT;
                        end
                    end
                end
                ST_WAIT: begin
                    if (wait_cond) begin
                        state_q <= ST_WAKE;
                    end
                end
                ST_WAKE: begin
                    // The wake-up slot brings a WAIT to six memory slots.
                    if (slot_done) begin
                        state_q <= ST_FETCH1;
                    end
                end
            endcase
        end
    end

    // Bus request: raised only at the start of an odd cycle, held for it.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            slot_q <= 1'b0;
            dma_q <= '0;
        end else if (vblank_start || jump1 || jump2) begin
            slot_q <= 1'b0;
            dma_q.req <= 1'b0;
        end else if (cyc_start && odd_q && run_en && state_q != ST_WAIT) begin
            slot_q <= 1'b1;
            dma_q.req <= 1'b1;
            dma_q.addr <= pc_q;
        end else if (cyc_end) begin
            slot_q <= 1'b0;
            dma_q.req <= 1'b0;
        end
    end

    // Register bus: marker on fetches, destination and data on MOVE.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            regbus_q <= '{wr: 1'b0, addr: ADDR_IDLE, data: RST_WORD};
        end else if (regbus_q.wr) begin
            regbus_q.wr <= 1'b0;
            regbus_q.addr <= ADDR_IDLE;
        end else if (cyc_start && odd_q && run_en && !(vblank_start || jump1 || jump2)
                     && (state_q == ST_FETCH1 || state_q == ST_FETCH2)) begin
            if (state_q == ST_FETCH2 && ir1_move) begin
                regbus_q.addr <= {ir1_q[8:1], 1'b0};
            end else begin
                regbus_q.addr <= ADDR_MARKER;
            end
        end else if (cyc_end) begin
            regbus_q.wr <= move_commit && move_ok;
            regbus_q.data <= dma_rdata;
            if (!(move_commit && move_ok)) begin
                regbus_q.addr <= ADDR_IDLE;
            end
        end
    end

    // Software read port; data stands in the cycle after the strobe only.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rdata_q <= RST_WORD;
        end else if (reg_rd) begin
            unique case (reg_addr)
                ADDR_CTRL: rdata_q <= ctrl_q;
                ADDR_DMACTL: rdata_q <= dmactl_q;
                ADDR_LOC1H: rdata_q <= {13'h0000, loc1h_q};
                ADDR_LOC1L: rdata_q <= {1'b0, loc1l_q};
                ADDR_LOC2H: rdata_q <= {13'h0000, loc2h_q};
                ADDR_LOC2L: rdata_q <= {1'b0, loc2l_q};
                ADDR_STATUS: rdata_q <= {12'h000, skip_q, slot_q, state_q};
                default: rdata_q <= RST_WORD;
            endcase
        end else begin
            rdata_q <= RST_WORD;
        end
    end

    assign reg_rdata = rdata_q;
    assign dma = dma_q;
    assign regbus = regbus_q;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    sequence seq_jump1;
        reg_wr && reg_addr == ADDR_JMP1 && !vblank_start;
    endsequence

    // Restarts are left out: a blank or a jump may legally end any wait.
    sequence seq_wait_blocked;
        state_q == ST_WAIT && !ir2_q[IR2_FD_BIT] && !blit_done
            && !vblank_start && !jump1 && !jump2;
    endsequence

    // A beam-test second word decoded as WAIT, with no restart in the same cycle.
    sequence seq_wait_decoded;
        state_q == ST_FETCH2 && slot_done && !ir1_move && !dma_rdata[IR2_SKIP_BIT]
            && !vblank_start && !jump1 && !jump2;
    endsequence

    // The same second word decoded as SKIP.
    sequence seq_skip_decoded;
        state_q == ST_FETCH2 && slot_done && !ir1_move && dma_rdata[IR2_SKIP_BIT]
            && !vblank_start && !jump1 && !jump2;
    endsequence

    AST_DANGER_RESET: assert property ($past(srst) |-> !ctrl_q[CTRL_DANGER_BIT])
        else $error("danger bit not cleared by reset");
    AST_BLIT_GUARD: assert property (regbus_q.wr && regbus_q.addr >= BLIT_LO
        && regbus_q.addr <= BLIT_HI |-> ctrl_q[CTRL_DANGER_BIT])
        else $error("blitter register written without danger bit");
    AST_JUMP_LOAD: assert property (seq_jump1 |=> pc_q == $past(ptr1)
        && state_q == ST_FETCH1)
        else $error("jump strobe did not load first pointer");
    AST_VBLANK_RELOAD: assert property (vblank_start |=> pc_q == $past(ptr1)
        && !dma_q.req)
        else $error("vertical blank did not reload program counter");
    AST_MARKER: assert property (dma_q.req && state_q == ST_FETCH1
        && !$past(regbus_q.wr) |-> regbus_q.addr == ADDR_MARKER)
        else $error("fetch cycle without marker address");
    AST_ODD_ONLY: assert property ($rose(dma_q.req) |-> odd_q && $past(run_en)
        && $past(cyc_start))
        else $error("bus requested outside an odd enabled cycle");
    AST_WAIT_OFF_BUS: assert property (state_q == ST_WAIT |-> !dma_q.req)
        else $error("request raised while waiting");
    AST_WAIT_FINISHED: assert property (seq_wait_blocked
        |=> state_q == ST_WAIT)
        else $error("wait ended without blitter finished flag");
    AST_SKIP_MOVE: assert property ($rose(regbus_q.wr) |-> !$past(skip_q))
        else $error("skipped move was written");
    AST_REQ_SPAN: assert property ($rose(dma_q.req) && !vblank_start
        && !jump1 && !jump2 |-> dma_q.req[*8])
        else $error("bus request shorter than expected");

    // Decode, stepping and the enables that gate the fetch.
    AST_WAIT_DECODE: assert property (seq_wait_decoded |=> state_q == ST_WAIT)
        else $error("wait word not decoded as wait");
    AST_SKIP_DECODE: assert property (seq_skip_decoded |=> state_q == ST_FETCH1)
        else $error("skip word did not return to fetch");
    AST_PC_STEP: assert property (state_q == ST_FETCH1 && slot_done && !vblank_start
        && !jump1 && !jump2 |=> pc_q == $past(pc_q) + PC_STEP)
        else $error("program counter did not step after first word");
    AST_RUN_GATE: assert property ($rose(dma_q.req) |-> $past(dmactl_q[DMA_MASTER_BIT])
        && $past(dmactl_q[DMA_COPROC_BIT]))
        else $error("request raised without both enables");
    AST_NO_REQ_DISABLED: assert property (!run_en && !dma_q.req |=> !dma_q.req)
        else $error("request raised while fetch disabled");

    // Wait release: the beam alone counts when the finished flag is ignored.
    AST_FD_IGNORES: assert property (state_q == ST_WAIT && ir2_q[IR2_FD_BIT]
        && beam_met(ir1_q, ir2_q, beam_v, beam_h, 1'b0) && !vblank_start
        && !jump1 && !jump2 |=> state_q == ST_WAKE)
        else $error("wait with finished flag ignored did not release");
    AST_WAKE_SLOT: assert property (state_q == ST_WAIT && wait_cond && !vblank_start
        && !jump1 && !jump2 |=> state_q == ST_WAKE)
        else $error("met wait did not go to the wake slot");

    // Register bus writes: a one-cycle pulse at the decoded destination only.
    AST_MOVE_DEST: assert property ($rose(regbus_q.wr)
        |-> regbus_q.addr == {ir1_q[8:1], 1'b0})
        else $error("move written to wrong destination");
    AST_REGBUS_PULSE: assert property (regbus_q.wr |=> !regbus_q.wr)
        else $error("register bus write pulse longer than one cycle");
    AST_BLIT_SUPPRESS: assert property (move_commit && move_blit
        && !ctrl_q[CTRL_DANGER_BIT] |=> !regbus_q.wr)
        else $error("blitter move written without danger bit");
endmodule

// File: sim/dlc_mem_model.sv
// Memory and bus arbiter model for the coprocessor's instruction fetch port.
`timescale 1ns/1ps
module dlc_mem_model
    import dlc_pkg::*;
(
    input wire logic sys_clk,
    input wire dlc_dma_t dma,
    input wire logic stall,
    output logic dma_gnt,
    output logic [15:0] dma_rdata
);
    logic [15:0] mem [0:63];
    logic [15:0] last_q = 16'h0000;

    // The coprocessor is granted unless a higher-ranked channel steals the slot.
    assign dma_gnt = dma.req && !stall;
    // Outside a granted slot the data lines show the inverse of the last word,
    // so a fetch that samples at the wrong time sees a wrong value.
    assign dma_rdata = dma_gnt ? mem[dma.addr[6:1]] : ~last_q;

    // Remember the last word driven onto the data lines.
    always @(posedge sys_clk) begin
        if (dma_gnt) begin
            last_q <= mem[dma.addr[6:1]];
        end
    end
endmodule

// File: sim/dlc_top_tb.sv
// Self-checking testbench of the display list coprocessor.
`timescale 1ns/1ps
module dlc_top_tb;
    import dlc_pkg::*;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic [8:0] reg_addr = 9'h000;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    dlc_dma_t dma;
    logic dma_gnt;
    logic [15:0] dma_rdata;
    dlc_regbus_t regbus;
    logic [7:0] beam_v = 8'h10;
    logic [6:0] beam_h = 7'h00;
    logic blit_done = 1'b0;
    logic vblank_start = 1'b0;
    logic stall = 1'b0;
    int fails = 0;
    int checks_done = 0;
    int cyc = 0;
    int last_rise = -1;
    logic req_q = 1'b0;
    logic [24:0] wq[$];
    // Program from byte 0x10 (words 8..39); the second list starts at byte 0x40 and
    // waits on the finished flag alone before its last MOVE and an endless WAIT.
    logic [15:0] prog [0:31] = '{16'h0040, 16'h1234, 16'h0180, 16'habcd, 16'h4001, 16'hff00,
        16'h0182, 16'h5555, 16'h0001, 16'h0001, 16'h0184, 16'h6666, 16'h0001, 16'h8001,
        16'h0186, 16'h7777, 16'h00ac, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
        16'h0000, 16'h0000, 16'h0188, 16'h8888, 16'h0001, 16'h0000, 16'h018a, 16'h9999,
        16'hffff, 16'hfffe};

    always #5 sys_clk = ~sys_clk;

    dlc_top u_dut (.sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dma(dma), .dma_gnt(dma_gnt),
        .dma_rdata(dma_rdata), .regbus(regbus), .beam_v(beam_v), .beam_h(beam_h),
        .blit_done(blit_done), .vblank_start(vblank_start));

    dlc_mem_model u_mem (.sys_clk(sys_clk), .dma(dma), .stall(stall), .dma_gnt(dma_gnt),
        .dma_rdata(dma_rdata));

    task automatic close_out();
        $display("Checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [24:0] exp, input logic [24:0] got);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One-cycle write strobe; it is lowered at the edge that takes it.
    task automatic wr(input logic [8:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so sample just past that edge.
    task automatic rdchk(input string what, input logic [8:0] a, input logic [15:0] exp);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk(what, 25'(exp), 25'(reg_rdata));
    endtask

    task automatic qchk(input int i, input logic [8:0] a, input logic [15:0] d);
        if (wq.size() <= i) begin
            chk("register bus write count", 25'(i + 1), 25'(wq.size()));
        end else begin
            chk("register bus write", {a, d}, wq[i]);
        end
    endtask

    task automatic wait_req();
        for (int i = 0; i < 300 && dma.req !== 1'b1; i++) begin
            @(posedge sys_clk);
        end
        #1;
    endtask

    // Logs register bus writes, checks request spacing and cuts a hang short.
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        req_q <= dma.req;
        if (regbus.wr === 1'b1) begin
            wq.push_back({regbus.addr, regbus.data});
        end
        if (srst === 1'b0 && dma.req === 1'b1 && req_q !== 1'b1) begin
            if (last_rise >= 0) begin
                chk("request spacing", 25'h0, 25'((cyc - last_rise) % 56));
            end
            last_rise <= cyc;
        end
        if (cyc > 20000) begin
            fails++;
            close_out();
        end
    end

    // Main sequence: registers, one pass through the program, then danger and blank.
    initial begin
        for (int i = 0; i < 32; i++) begin
            u_mem.mem[8 + i] = prog[i];
        end
        repeat (5) @(posedge sys_clk);
        srst <= 1'b0;
        rdchk("control after reset", ADDR_CTRL, 16'h0000);
        rdchk("jump strobe read", ADDR_JMP1, 16'h0000);
        rdchk("unmapped read", 9'h1f0, 16'h0000);
        wr(ADDR_LOC1H, 16'hffff);
        rdchk("first location high", ADDR_LOC1H, 16'h0007);
        wr(ADDR_LOC1H, 16'h0000);
        wr(ADDR_LOC1L, 16'h0010);
        rdchk("first location low", ADDR_LOC1L, 16'h0010);
        wr(ADDR_LOC2H, 16'h0000);
        wr(ADDR_LOC2L, 16'h0040);
        rdchk("second location low", ADDR_LOC2L, 16'h0040);
        wr(ADDR_JMP1, 16'h0000);
        stall <= 1'b1;
        wr(ADDR_DMACTL, 16'h0280);
        wait_req();
        chk("first fetch address", 25'h10, 25'(dma.addr));
        repeat (300) @(posedge sys_clk);
        stall <= 1'b0;
        repeat (1500) @(posedge sys_clk);
        chk("writes while waiting", 25'h1, 25'(wq.size()));
        qchk(0, 9'h180, 16'habcd);
        rdchk("status while waiting", ADDR_STATUS, 16'h0002);
        rdchk("dma control", ADDR_DMACTL, 16'h0280);
        beam_v <= 8'h40;
        repeat (1500) @(posedge sys_clk);
        qchk(1, 9'h182, 16'h5555);
        qchk(2, 9'h184, 16'h6666);
        qchk(3, 9'h0ac, 16'h0000);
        qchk(4, 9'h188, 16'h8888);
        chk("writes after pass", 25'h5, 25'(wq.size()));
        blit_done <= 1'b1;
        repeat (400) @(posedge sys_clk);
        qchk(5, 9'h18a, 16'h9999);
        wr(ADDR_CTRL, 16'h0002);
        rdchk("control danger set", ADDR_CTRL, 16'h0002);
        @(posedge sys_clk);
        vblank_start <= 1'b1;
        @(posedge sys_clk);
        vblank_start <= 1'b0;
        wait_req();
        chk("fetch after blank", 25'h10, 25'(dma.addr));
        repeat (300) @(posedge sys_clk);
        qchk(6, 9'h040, 16'h1234);
        close_out();
    end
endmodule
